// *** testbench/dmr6_chk.sv ***
// link checker for the mode register link between the two ends
`timescale 1ns/100ps
`default_nettype none
module dmr6_chk (
   input wire logic                 CLK,
   input wire logic                 RST_N,
   input wire logic                 cs_n,
   input wire logic                 act_n,
   input wire dmr6_pkg::dmr6_addr_t addr,
   input wire logic [1:0]           bg,
   input wire logic [1:0]           ba,
   input wire dmr6_pkg::dmr6_cmd_t  cmd,
   input wire logic                 command_address_check_bit,
   input wire logic                 crc_fail,
   input wire logic                 status_crc,
   input wire logic                 status_par
);
   // ----------------------------------------
   // decoded commands
   // ----------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   wire logic       mrs = !cs_n && cmd == dmr6_pkg::DMR6_CMD_MRS;
   wire logic [2:0] sel = {bg[0], ba};
   wire logic       par_ok = command_address_check_bit == ^{act_n, addr, bg, ba};
   wire logic       clr_crc = mrs && sel == 3'h5 && addr[3];
   wire logic       clr_par = mrs && sel == 3'h5 && addr[4];
   // a clear only wins when no fresh mismatch arrives with it
   sequence s_clear_crc;
      status_crc && clr_crc && !crc_fail;
   endsequence
   a_par_even: assert property (mrs |-> par_ok)
      else $error("check bit wrong");
   // status pins copy the sticky bit one edge late: an event shows two edges on
   a_crc_set: assert property (crc_fail |=> ##1 status_crc)
      else $error("crc status not set");
   a_crc_clear: assert property (s_clear_crc |=> ##1 !status_crc)
      else $error("crc status not cleared");
   a_crc_hold: assert property ($fell(status_crc) |-> $past(clr_crc, 2))
      else $error("crc status dropped alone");
   a_crc_keep: assert property (status_crc && !$past(clr_crc) |=> status_crc [*1])
      else $error("crc status lost");
   a_par_hold: assert property ($fell(status_par) |-> $past(clr_par, 2))
      else $error("parity status dropped alone");
   a_par_keep: assert property (status_par && !$past(clr_par) |=> status_par)
      else $error("parity status lost");
   a_no_unused: assert property (mrs |-> sel != 3'h7)
      else $error("unused select sent");
   a_rfu_zero: assert property (mrs |-> !bg[1])
      else $error("reserved bit driven");
endmodule
`default_nettype wire

// *** testbench/tb_ddr4_mr6_and_error_status.sv ***
// self-checking bench for both ends of the mode register link
`timescale 1ns/100ps
`default_nettype none
module tb_ddr4_mr6_and_error_status;
   logic        clk, rst_n, wr, rd, crc_in, rd_d, irq, applied, en, r2, pers_b;
   logic [3:0]  addr, gap;
   logic [31:0] wdata, rdata, lf;
   logic [5:0]  val, val_b;
   logic [13:0] lvl;
   logic [2:0]  plat, plat_b;
   logic [25:0] m_cfg;
   logic [31:0] q_rd[$];
   logic [25:0] q_cfg[$];
   int          n_errors, n_tests;
   dmr6_if link_a();
   dmr6_if link_b();
   dmr6_ctrl i_dmr6_ctrl (.CLK(clk), .RST_N(rst_n), .link(link_a), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .CRC_FAIL_IN(crc_in));
   dmr6_device i_dmr6_device (.CLK(clk), .RST_N(rst_n), .link(link_a), .TRAIN_EN(en),
      .TRAIN_RANGE2(r2), .TRAIN_VALUE(val), .TRAIN_LEVEL(lvl), .GAP_CLOCKS(gap),
      .PARITY_LATENCY(plat), .PERSIST_MODE(), .MRS_APPLIED(applied));
   // second device faces the bench, which breaks parity on purpose
   dmr6_device i_dmr6_device_b (.CLK(clk), .RST_N(rst_n), .link(link_b), .TRAIN_EN(),
      .TRAIN_RANGE2(), .TRAIN_VALUE(val_b), .TRAIN_LEVEL(), .GAP_CLOCKS(),
      .PARITY_LATENCY(plat_b), .PERSIST_MODE(pers_b), .MRS_APPLIED());
   dmr6_chk i_dmr6_chk (.CLK(clk), .RST_N(rst_n), .cs_n(link_a.cs_n), .act_n(link_a.act_n),
      .addr(link_a.addr), .bg(link_a.bg), .ba(link_a.ba), .cmd(link_a.cmd),
      .command_address_check_bit(link_a.command_address_check_bit),
      .crc_fail(link_a.crc_fail), .status_crc(link_a.status_crc),
      .status_par(link_a.status_par));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      q_rd.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic mrs(input logic [2:0] s, input logic [17:0] v);
      wr_reg(4'h1, {29'h0, s});
      wr_reg(4'h0, {14'h0, v});
      if (s == 3'h6) begin
         m_cfg[25:18] = v[7:0];
         m_cfg[17:4] = (v[6] ? 14'h1194 : 14'h1770) + 14'h0041 * 14'(v[5:0]);
         if (v[12:10] <= 3'h4)
            m_cfg[3:0] = 4'h4 + {1'b0, v[12:10]};
      end
      if (s != 3'h7)
         q_cfg.push_back(m_cfg);
      repeat (4) @(posedge clk);
   endtask
   // released address lines show the inverse so stale values cannot pass
   task automatic drv_b(input logic [2:0] s, input logic [17:0] a, input logic bad,
                        input logic [6:0] e);
      @(posedge clk);
      link_b.cs_n <= 1'b0;
      link_b.cmd <= dmr6_pkg::DMR6_CMD_MRS;
      link_b.addr <= a;
      link_b.bg <= {1'b0, s[2]};
      link_b.ba <= s[1:0];
      link_b.odt <= lf[0];
      link_b.command_address_check_bit <= ^{1'b1, a, 1'b0, s} ^ bad;
      lf = lfsr(lf);
      @(posedge clk);
      link_b.cs_n <= 1'b1;
      link_b.cmd <= dmr6_pkg::DMR6_CMD_NOP;
      link_b.addr <= ~a;
      repeat (3) @(posedge clk);
      check({val_b, link_b.status_par} === e, "far device state");
   endtask
   always @(posedge clk) begin
      rd_d <= rd;
      if (rd_d)
         check(rdata === q_rd.pop_front(), "read data");
      if (applied === 1'b1)
         check({en, r2, val, lvl, gap} === q_cfg.pop_front(), "fields");
   end
   task automatic summarize();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge clk);
      n_errors++;
      summarize();
   end
   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial begin
      {wr, rd, crc_in, addr, wdata, n_errors, n_tests} = '0;
      lf = 32'h916E;
      m_cfg = {8'h00, 14'h1770, 4'h4};
      {link_b.cs_n, link_b.act_n, link_b.cke, link_b.odt, link_b.crc_fail} = 5'h1C;
      {link_b.addr, link_b.bg, link_b.ba, link_b.command_address_check_bit} = '0;
      link_b.cmd = dmr6_pkg::DMR6_CMD_NOP;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(4'h2, 32'h0);
      rd_reg(4'hF, 32'h0);
      check({m_cfg, plat} === {en, r2, val, lvl, gap, 3'h0}, "reset fields");
      for (int i = 0; i < 10; i++) begin
         lf = lfsr(lf);
         mrs(3'h6, {5'h00, i[2:0], 2'h0, lf[7:6], (i == 8) ? 6'h32 : (i == 9) ? 6'h00 :
             6'(lf[5:0] % 6'h33)});
      end
      rd_reg(4'h2, 32'h1);
      $display("test fields done");
      wr_reg(4'h2, 32'hF);
      wr_reg(4'h3, 32'h8);
      mrs(3'h7, 18'h0);
      rd_reg(4'h2, 32'h8);
      check(irq === 1'b1, "irq not raised");
      wr_reg(4'h3, 32'h0);
      repeat (2) @(posedge clk);
      check(irq === 1'b0, "irq not masked");
      wr_reg(4'h3, 32'h2);
      wr_reg(4'h2, 32'h8);
      crc_in <= 1'b1;
      @(posedge clk);
      crc_in <= 1'b0;
      repeat (30) @(posedge clk);
      rd_reg(4'h4, 32'h1);
      rd_reg(4'h2, 32'h2);
      check(irq === 1'b1, "irq crc");
      mrs(3'h5, 18'h8);
      rd_reg(4'h4, 32'h0);
      $display("test status done");
      drv_b(3'h6, 18'h05, 1'b1, {6'h05, 1'b0});
      drv_b(3'h7, 18'h3F, 1'b0, {6'h05, 1'b0});
      drv_b(3'h5, 18'h01, 1'b0, {6'h05, 1'b0});
      check({pers_b, plat_b} === 4'h1, "latency field");
      drv_b(3'h6, 18'h09, 1'b1, {6'h05, 1'b1});
      drv_b(3'h6, 18'h0A, 1'b1, {6'h0A, 1'b1});
      drv_b(3'h5, 18'h211, 1'b0, {6'h0A, 1'b0});
      check({pers_b, plat_b} === 4'h9, "mode five fields");
      drv_b(3'h6, 18'h07, 1'b1, {6'h0A, 1'b1});
      drv_b(3'h6, 18'h08, 1'b1, {6'h0A, 1'b1});
      drv_b(3'h6, 18'h0C, 1'b0, {6'h0C, 1'b1});
      $display("test parity done");
      summarize();
   end
endmodule
`default_nettype wire

// *** verilog/dmr6_consts.svh ***
// constants for the mode register six and error status block
`ifndef DMR6_CONSTS_SVH
`define DMR6_CONSTS_SVH
// ----------------------------------------------------------------
// mode register select codes on bg0,ba1,ba0
// ----------------------------------------------------------------
`define DMR6_SEL_MR5          3'h5
`define DMR6_SEL_MR6          3'h6
`define DMR6_SEL_UNUSED       3'h7
// ----------------------------------------------------------------
// mode register six field positions
// ----------------------------------------------------------------
`define DMR6_VAL_LSB          0
`define DMR6_VAL_MSB          5
`define DMR6_RANGE_BIT        6
`define DMR6_TRAIN_BIT        7
`define DMR6_GAP_LSB          10
`define DMR6_GAP_MSB          12
`define DMR6_VAL_MAX          6'h32
`define DMR6_GAP_MAX          3'h4
`define DMR6_GAP_BASE         4'h4
`define DMR6_LVL_R1_BASE      14'h1770
`define DMR6_LVL_R2_BASE      14'h1194
`define DMR6_LVL_STEP         14'h0041
// ----------------------------------------------------------------
// mode register five fields: parity latency, clear, persistent mode
// ----------------------------------------------------------------
`define DMR6_PL_LSB           0
`define DMR6_PL_MSB           2
`define DMR6_CLR_CRC_BIT      3
`define DMR6_CLR_PAR_BIT      4
`define DMR6_PERSIST_BIT      9
// ----------------------------------------------------------------
// controller register map
// ----------------------------------------------------------------
`define DMR6_REG_CMD          4'h0
`define DMR6_REG_SEL          4'h1
`define DMR6_REG_STATUS       4'h2
`define DMR6_REG_MASK         4'h3
`define DMR6_REG_DEVSTAT      4'h4
`define DMR6_ST_DONE          0
`define DMR6_ST_CRC           1
`define DMR6_ST_PAR           2
`define DMR6_ST_REFUSED       3
`endif

// *** verilog/dmr6_ctrl.sv ***
// controller end: issues mode register commands from a software port
//
// Decided for this implementation: strobed register access.
`include "dmr6_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dmr6_ctrl (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   dmr6_if.ctrl             link,
   input  wire logic [3:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [31:0]      RDATA,
   output logic             IRQ,
   input  wire logic        CRC_FAIL_IN
);
   // ----------------------------------------------------------------
   // registers and command issue
   // ----------------------------------------------------------------
   logic [2:0] sel_q;
   logic [3:0] stat_q;
   logic [3:0] mask_q;
   logic       s_crc;
   logic       s_crc_m;
   logic       s_par;
   logic       s_par_m;
   logic       s_crc_d;
   logic       s_par_d;
   logic       issue;
   logic       bad;
   logic [3:0] ev;
   logic [17:0] mrs_addr;
   logic       par_calc;

   assign issue    = WR && ADDR == `DMR6_REG_CMD;
   // reserved select codes refused here, never sent (see RULE_09)
   assign bad      = sel_q == `DMR6_SEL_UNUSED;
   // only 18 address bits exist; higher write bits dropped, zeros kept (see RULE_10)
   assign mrs_addr = WDATA[17:0];

   dmr6_parity u_par (
      .act_n (1'b1),
      .addr  (mrs_addr),
      .bg    ({1'b0, sel_q[2]}),
      .ba    (sel_q[1:0]),
      .par   (par_calc)
   );

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         link.cs_n <= 1'b1;
         link.act_n <= 1'b1;
         link.cke <= 1'b1;
         link.odt <= 1'b0;
         link.addr <= 18'h00000;
         link.bg <= 2'h0;
         link.ba <= 2'h0;
         link.cmd <= dmr6_pkg::DMR6_CMD_NOP;
         link.command_address_check_bit <= 1'b0;
         link.crc_fail <= 1'b0;
      end else begin
         link.crc_fail <= CRC_FAIL_IN;
         link.cs_n <= !(issue && !bad);
         link.cmd  <= (issue && !bad) ? dmr6_pkg::DMR6_CMD_MRS : dmr6_pkg::DMR6_CMD_NOP;
         if (issue && !bad) begin
            link.addr <= mrs_addr; // gap value is software's job (see RULE_11)
            link.bg   <= {1'b0, sel_q[2]};
            link.ba   <= sel_q[1:0];
            link.command_address_check_bit <= par_calc;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sel_q  <= 3'h0;
         mask_q <= 4'h0;
      end else if (WR) begin
         if (ADDR == `DMR6_REG_SEL) sel_q <= WDATA[2:0];
         if (ADDR == `DMR6_REG_MASK) mask_q <= WDATA[3:0];
      end
   end

   // ----------------------------------------------------------------
   // status events: two-flop view of device status, rising edges latch
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_crc_m <= 1'b0;
         s_crc   <= 1'b0;
         s_par_m <= 1'b0;
         s_par   <= 1'b0;
         s_crc_d <= 1'b0;
         s_par_d <= 1'b0;
      end else begin
         s_crc_m <= link.status_crc;
         s_crc   <= s_crc_m;
         s_par_m <= link.status_par;
         s_par   <= s_par_m;
         s_crc_d <= s_crc;
         s_par_d <= s_par;
      end
   end

   assign ev = {issue && bad, s_par && !s_par_d, s_crc && !s_crc_d, issue && !bad};

   // set wins over write-one-to-clear
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         stat_q <= 4'h0;
      end else begin
         stat_q <= ev | (stat_q & ~((WR && ADDR == `DMR6_REG_STATUS) ? WDATA[3:0] : 4'h0));
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         IRQ   <= 1'b0;
         RDATA <= 32'h00000000;
      end else begin
         IRQ <= |(stat_q & mask_q);
         if (RD) begin
            unique case (ADDR)
               `DMR6_REG_SEL:     RDATA <= {29'h0, sel_q};
               `DMR6_REG_STATUS:  RDATA <= {28'h0, stat_q};
               `DMR6_REG_MASK:    RDATA <= {28'h0, mask_q};
               `DMR6_REG_DEVSTAT: RDATA <= {30'h0, s_par, s_crc};
               default:           RDATA <= 32'h00000000;
            endcase
         end else begin
            RDATA <= 32'h00000000;
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/dmr6_device.sv ***
// device end: mode register decode, register six, parity and crc status
// Operation
// RULE_01 - crc mismatch sets crc error status
// RULE_02 - crc status sticks until mrs clear
// RULE_03 - parity checks only with nonzero latency
// RULE_04 - parity checking disabled after initialisation
// RULE_05 - parity-failed commands are never executed
// RULE_06 - parity covers act, a17..a0, bg, ba
// RULE_07 - cke, odt, chip select excluded
// RULE_08 - select code 111 ignored, no response
// RULE_09 - controller never writes reserved codes
// RULE_10 - controller drives reserved bits zero
// RULE_11 - controller programs gap per frequency
// RULE_12 - training code maps to level
// RULE_13 - training codes above 110010 not programmed
// RULE_14 - gap code 000..100 gives 4..8 clocks
// RULE_15 - a7 enables training, a6 picks range
// RULE_16 - parity error sets sticky status
// RULE_17 - non-persistent mode stops checking when set
`include "dmr6_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dmr6_device (
   input  wire logic   CLK,
   input  wire logic   RST_N,
   dmr6_if.dev         link,
   output logic        TRAIN_EN,
   output logic        TRAIN_RANGE2,
   output logic [5:0]  TRAIN_VALUE,
   output logic [13:0] TRAIN_LEVEL,
   output logic [3:0]  GAP_CLOCKS,
   output logic [2:0]  PARITY_LATENCY,
   output logic        PERSIST_MODE,
   output logic        MRS_APPLIED
);
   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   logic                 par_calc;
   logic                 check_on;
   logic                 par_bad;
   logic                 mrs_take;
   dmr6_pkg::dmr6_sel_t  sel;
   logic [2:0]           pl_q;
   logic                 persist_q;
   logic                 crc_q;
   logic                 par_q;

   dmr6_parity u_par (
      .act_n (link.act_n),
      .addr  (link.addr),
      .bg    (link.bg),
      .ba    (link.ba),
      .par   (par_calc)
   );

   assign sel      = {link.bg[0], link.ba};
   // latency zero means off; reset value zero (see RULE_03) (see RULE_04)
   assign check_on = (pl_q != 3'h0) && (persist_q || !par_q); // see RULE_17
   assign par_bad  = !link.cs_n && check_on && (par_calc != link.command_address_check_bit);
   // a failing command is dropped before it takes effect (see RULE_05)
   assign mrs_take = !link.cs_n && (link.cmd == dmr6_pkg::DMR6_CMD_MRS) && !par_bad
                     && (sel != `DMR6_SEL_UNUSED); // see RULE_08

   // ----------------------------------------------------------------
   // mode register five subset: parity latency and persistent mode
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pl_q      <= 3'h0;
         persist_q <= 1'b0;
      end else if (mrs_take && sel == `DMR6_SEL_MR5) begin
         pl_q      <= link.addr[`DMR6_PL_MSB:`DMR6_PL_LSB];
         persist_q <= link.addr[`DMR6_PERSIST_BIT];
      end
   end

   // ----------------------------------------------------------------
   // sticky status; a new event wins over a clear in the same cycle
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         crc_q <= 1'b0;
      end else if (link.crc_fail) begin
         crc_q <= 1'b1; // see RULE_01
      end else if (mrs_take && sel == `DMR6_SEL_MR5 && link.addr[`DMR6_CLR_CRC_BIT]) begin
         crc_q <= 1'b0; // see RULE_02
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         par_q <= 1'b0;
      end else if (par_bad) begin
         par_q <= 1'b1; // see RULE_16
      end else if (mrs_take && sel == `DMR6_SEL_MR5 && link.addr[`DMR6_CLR_PAR_BIT]) begin
         par_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   logic [2:0]  gap_code;
   logic [5:0]  val_code;
   logic [13:0] lvl_base;
   assign gap_code = link.addr[`DMR6_GAP_MSB:`DMR6_GAP_LSB];
   assign val_code = link.addr[`DMR6_VAL_MSB:`DMR6_VAL_LSB];
   assign lvl_base = link.addr[`DMR6_RANGE_BIT] ? `DMR6_LVL_R2_BASE : `DMR6_LVL_R1_BASE;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         TRAIN_EN       <= 1'b0;
         TRAIN_RANGE2   <= 1'b0;
         TRAIN_VALUE    <= 6'h00;
         TRAIN_LEVEL    <= `DMR6_LVL_R1_BASE;
         GAP_CLOCKS     <= `DMR6_GAP_BASE;
         PARITY_LATENCY <= 3'h0;
         PERSIST_MODE   <= 1'b0;
         MRS_APPLIED    <= 1'b0;
         link.status_crc <= 1'b0;
         link.status_par <= 1'b0;
      end else begin
         MRS_APPLIED     <= mrs_take;
         PARITY_LATENCY  <= pl_q;
         PERSIST_MODE    <= persist_q;
         link.status_crc <= crc_q;
         link.status_par <= par_q;
         if (mrs_take && sel == `DMR6_SEL_MR6) begin
            TRAIN_EN     <= link.addr[`DMR6_TRAIN_BIT]; // see RULE_15
            TRAIN_RANGE2 <= link.addr[`DMR6_RANGE_BIT];
            TRAIN_VALUE  <= val_code;
            // level in hundredths of a percent; reserved codes saturate (see RULE_12)
            TRAIN_LEVEL  <= lvl_base + 14'((val_code > `DMR6_VAL_MAX ? `DMR6_VAL_MAX : val_code)
                            * `DMR6_LVL_STEP);
            // reserved gap codes keep the old spacing (see RULE_14)
            if (gap_code <= `DMR6_GAP_MAX) begin
               GAP_CLOCKS <= `DMR6_GAP_BASE + {1'b0, gap_code};
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/dmr6_if.sv ***
// command/address link between the controller and the device
`timescale 1ns/100ps
`default_nettype none
interface dmr6_if;
   logic              cs_n;
   logic              act_n;
   logic              cke;
   logic              odt;
   dmr6_pkg::dmr6_addr_t addr;
   logic [1:0]        bg;
   logic [1:0]        ba;
   dmr6_pkg::dmr6_cmd_t cmd;
   logic              command_address_check_bit;
   logic              crc_fail;
   logic              status_crc;
   logic              status_par;
   modport ctrl (output cs_n, act_n, cke, odt, addr, bg, ba, cmd, command_address_check_bit,
                 output crc_fail, input status_crc, status_par);
   modport dev  (input cs_n, act_n, cke, odt, addr, bg, ba, cmd, command_address_check_bit,
                 input crc_fail, output status_crc, status_par);
endinterface
`default_nettype wire

// *** verilog/dmr6_parity.sv ***
// even parity over the command/address lines that the check covers
`timescale 1ns/100ps
`default_nettype none
module dmr6_parity (
   input  wire logic                 act_n,
   input  wire dmr6_pkg::dmr6_addr_t addr,
   input  wire logic [1:0]           bg,
   input  wire logic [1:0]           ba,
   output logic                      par
);
   // cke, odt and chip select deliberately left out (see RULE_07)
   assign par = ^{act_n, addr, bg, ba}; // see RULE_06
endmodule
`default_nettype wire

// *** verilog/dmr6_pkg.sv ***
// types shared by both ends of the mode register link
package dmr6_pkg;
   typedef logic [17:0] dmr6_addr_t;
   typedef logic [2:0]  dmr6_sel_t;
   typedef enum logic [1:0] {DMR6_CMD_NOP, DMR6_CMD_MRS, DMR6_CMD_OTHER} dmr6_cmd_t;
endpackage
